// file: rtl/host_irq_pkg.sv
package host_irq_pkg;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL_ZERO = 8'h00;
  localparam logic [7:0] OFS_CAUSE_MASK = 8'h04;
  localparam logic [7:0] OFS_EVT_HIST  = 8'h08;
  localparam logic [7:0] OFS_TX_STATUS = 8'h0C;
  localparam logic [7:0] OFS_INIT_BASE = 8'h10;

  // Control bits of status_control_reg_zero
  localparam int BIT_INIT      = 0;
  localparam int BIT_START     = 1;
  localparam int BIT_STOP      = 2;
  localparam int BIT_INT_EN    = 6;
  localparam int BIT_INT_FLAG  = 7;
  localparam int CAUSE_LSB     = 8;
  localparam int BIT_ERR_SUM   = 15;

  // Cause vector: index within the flag field
  localparam int CAUSE_W       = 7;
  localparam int C_INIT_DONE   = 0;
  localparam int C_TX          = 1;
  localparam int C_RX          = 2;
  localparam int C_ERR_LSB     = 3;
  localparam int C_ERR_MSB     = 6;

  localparam logic [CAUSE_W-1:0] MASK_RESET = 7'h7F;
  localparam logic [7:0]         INIT_WORDS_DEF = 8'h0C;
  localparam logic [23:0]        WORD_BYTES = 24'h000002;
  localparam logic [23:0]        TX_STATUS_OFS = 24'h000002;

  // Transmit status word fields
  localparam int TX_BIT_ERR     = 14;
  localparam int TX_BIT_MORE    = 12;
  localparam int TX_BIT_ONE     = 11;
  localparam int TX_BIT_BUFF    = 10;
  localparam int TX_BIT_UNDER   = 9;
  localparam int TX_BIT_LATE    = 8;
  localparam int TX_BIT_CARRIER = 7;
  localparam int TX_BIT_RETRY   = 6;

  typedef enum logic {INIT_IDLE, INIT_FETCH} init_state_t;

endpackage

// file: rtl/tx_status_word_builder.sv
module tx_status_word_builder
  import host_irq_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        frame_done_i,
  input  wire logic [3:0]  retries_i,
  input  wire logic        err_retry_i,
  input  wire logic        err_carrier_i,
  input  wire logic        err_late_coll_i,
  input  wire logic        err_underflow_i,
  input  wire logic        err_buffer_i,
  input  wire logic [23:0] desc_addr_i,
  output logic             wr_o,
  output logic [23:0]      wr_addr_o,
  output logic [15:0]      wr_data_o,
  output logic             done_o
);

  typedef struct packed {
    logic        wr;
    logic [23:0] addr;
    logic [15:0] word;
  } tx_st_t;

  tx_st_t st_reg;
  tx_st_t st_next;

  // Build the status word for one finished frame
  always_comb
  begin
    logic [15:0] w;
    logic        any_err;
    w       = 16'h0000;
    any_err = err_retry_i | err_carrier_i | err_late_coll_i | err_underflow_i | err_buffer_i;
    st_next = st_reg;
    st_next.wr = 1'b0;
    if (frame_done_i)
    begin
      w[TX_BIT_MORE]    = (retries_i > 4'h1); // [R10]
      w[TX_BIT_ONE]     = (retries_i == 4'h1); // [R10]
      w[TX_BIT_RETRY]   = err_retry_i; // [R11]
      w[TX_BIT_CARRIER] = err_carrier_i; // [R11]
      w[TX_BIT_LATE]    = err_late_coll_i; // [R11]
      w[TX_BIT_UNDER]   = err_underflow_i; // [R11]
      w[TX_BIT_BUFF]    = err_buffer_i; // [R11]
      w[TX_BIT_ERR]     = any_err; // [R11]
      st_next.wr   = 1'b1;
      st_next.word = w;
      st_next.addr = desc_addr_i + TX_STATUS_OFS; // [R09]
    end
  end

  // Hold the word for its one-cycle writeback
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  // Outputs straight from the register
  assign wr_o      = st_reg.wr;
  assign wr_addr_o = st_reg.addr;
  assign wr_data_o = st_reg.word;
  assign done_o    = st_reg.wr; // Status written back, raise transmit cause

endmodule // tx_status_word_builder

// file: rtl/host_interrupt_status_logic.sv
// Contract
// (R01) Interrupt on frame sent, frame received, initialization done or error.
// (R02) Register zero shows error summary, transmit, receive and init-done flags together.
// (R03) Writing one clears a flag in register zero; writing zero leaves it.
// (R04) Error summary is not writable; it drops once all error flags clear.
// (R05) Interrupt enable is bit 6 of register zero; zero there disables interrupt.
// (R06) Interrupt output is OR of pending causes gated by enable.
// (R07) No new edge while interrupt already high; host checks every flag.
// (R08) Error summary set only while some individual error flag is set.
// (R09) Transmit status goes to the descriptor word two bytes past its start.
// (R10) Status word flags more-than-one-retry and exactly-one-retry separately.
// (R11) Status word holds error summary plus retry, carrier, late, underflow, buffer.
// (R12) Host wraps its last-transmit pointer to ring start past the last entry.
// (R13) In loopback host holds transmit buffer until received data is compared.
// (R14) Host reruns the register init sequence after loading a new mode.
// (R15) Writing 0043 hex sets enable, start, init; fetches twelve init words.
// (R16) With enable clear, init completion only sets the flag for polling.
module host_interrupt_status_logic
  import host_irq_pkg::*;
#(
  parameter logic [7:0] INIT_WORDS = INIT_WORDS_DEF
)
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  output logic             irq_o,
  input  wire logic        rx_done_i,
  input  wire logic        mem_err_i,
  input  wire logic        missed_i,
  input  wire logic        coll_err_i,
  input  wire logic        babble_i,
  input  wire logic        tx_done_i,
  input  wire logic [3:0]  tx_retries_i,
  input  wire logic        tx_err_retry_i,
  input  wire logic        tx_err_carrier_i,
  input  wire logic        tx_err_late_coll_i,
  input  wire logic        tx_err_underflow_i,
  input  wire logic        tx_err_buffer_i,
  input  wire logic [23:0] tx_desc_addr_i,
  output logic             desc_wr_o,
  output logic [23:0]      desc_wr_addr_o,
  output logic [15:0]      desc_wr_data_o,
  output logic             init_dma_req_o,
  output logic [23:0]      init_dma_addr_o,
  input  wire logic        init_dma_ack_i,
  output logic             running_o
);

  import host_irq_pkg::*;

  // Refuse an empty init block
  if (INIT_WORDS == 8'h00)
  begin : g_bad_words
    $error("INIT_WORDS must be at least one");
  end

  // Flag field must sit below the summary bit
  if (CAUSE_LSB + CAUSE_W > BIT_ERR_SUM)
  begin : g_bad_field
    $error("cause field overlaps the summary bit");
  end

  // Error flags must lie inside the flag field
  if (C_ERR_MSB >= CAUSE_W)
  begin : g_bad_err_top
    $error("error flags run past the cause field");
  end

  // Error flag range must not be reversed
  if (C_ERR_LSB > C_ERR_MSB)
  begin : g_bad_err_order
    $error("error flag range reversed");
  end

  // Whole state of the block, registered as one
  typedef struct packed {
    logic              ack;
    logic [31:0]       dat;
    logic              int_en;
    logic              run;
    logic [CAUSE_W-1:0] cause;
    logic [CAUSE_W-1:0] mask;
    logic [CAUSE_W-1:0] hist;
    logic [15:0]       tx_word;
    logic [23:0]       init_base;
    init_state_t       init_st;
    logic [7:0]        word_cnt;
    logic [23:0]       dma_addr; // Address of the next word to fetch
    logic              irq;
  } state_t;

  // Current and next copy of the state
  state_t st_reg;
  state_t st_next;

  // Writeback results of the transmit side
  logic        tx_wr;
  logic [23:0] tx_addr;
  logic [15:0] tx_word;
  logic        tx_event;

  // Per-frame transmit status writeback
  tx_status_word_builder u_tx_status
  (
    .clk_i           (clk_i),
    .rst_i           (rst_i),
    .frame_done_i    (tx_done_i),
    .retries_i       (tx_retries_i),
    .err_retry_i     (tx_err_retry_i),
    .err_carrier_i   (tx_err_carrier_i),
    .err_late_coll_i (tx_err_late_coll_i),
    .err_underflow_i (tx_err_underflow_i),
    .err_buffer_i    (tx_err_buffer_i),
    .desc_addr_i     (tx_desc_addr_i),
    .wr_o            (tx_wr),
    .wr_addr_o       (tx_addr),
    .wr_data_o       (tx_word),
    .done_o          (tx_event)
  );

  // Bus decode and flag helpers
  logic               req;
  logic               acc;
  logic               wr_acc;
  logic [7:0]         adr;
  logic [31:0]        wmask;
  logic               init_done;
  logic [CAUSE_W-1:0] events;
  logic [CAUSE_W-1:0] w1c;
  logic               err_sum;
  logic               pending;
  logic [31:0]        reg0_view;
  logic [31:0]        rdata;

  // Bus decode: request, accepted access, byte lanes
  always_comb
  begin
    req    = wb_cyc_i & wb_stb_i;
    acc    = req & st_reg.ack;
    wr_acc = acc & wb_we_i;
    adr    = {wb_adr_i[7:2], 2'b00};
    wmask  = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  end

  // Cause events and the register zero view
  always_comb
  begin
    init_done = (st_reg.init_st == INIT_FETCH) && init_dma_ack_i
                && (st_reg.word_cnt == INIT_WORDS - 8'h01);
    events = {babble_i, coll_err_i, missed_i, mem_err_i, rx_done_i, tx_event,
              init_done}; // [R01]
    w1c = (wr_acc && adr == OFS_CTRL_ZERO)
          ? (wb_dat_i[CAUSE_LSB +: CAUSE_W] & wmask[CAUSE_LSB +: CAUSE_W])
          : '0; // [R03]
    err_sum = |st_reg.cause[C_ERR_MSB:C_ERR_LSB]; // [R04] [R08]
    pending = |(st_reg.cause & st_reg.mask); // [R06]
    reg0_view = 32'h00000000;
    reg0_view[BIT_INIT]     = (st_reg.init_st == INIT_FETCH);
    reg0_view[BIT_START]    = st_reg.run;
    reg0_view[BIT_STOP]     = ~st_reg.run;
    reg0_view[BIT_INT_EN]   = st_reg.int_en;
    reg0_view[BIT_INT_FLAG] = pending;
    reg0_view[CAUSE_LSB +: CAUSE_W] = st_reg.cause; // [R02]
    reg0_view[BIT_ERR_SUM]  = err_sum; // [R02]
  end

  logic [CAUSE_W-1:0] cause_next;
  logic [CAUSE_W-1:0] hist_next;
  logic               hist_rd;

  // A read of the history register empties it
  assign hist_rd = acc & ~wb_we_i & (adr == OFS_EVT_HIST);

  // Sticky flags per bit; an event in the clearing cycle wins
  for (genvar i = 0; i < CAUSE_W; i++)
  begin : g_flag
    assign cause_next[i] = (st_reg.cause[i] & ~w1c[i]) | events[i]; // [R03]
    assign hist_next[i]  = (st_reg.hist[i] & ~hist_rd) | events[i];
  end

  // Read data mux, unmapped reads as zero
  always_comb
  begin
    case (adr)
      OFS_CTRL_ZERO:  rdata = reg0_view;
      OFS_CAUSE_MASK: rdata = {25'h0000000, st_reg.mask};
      OFS_EVT_HIST:   rdata = {25'h0000000, st_reg.hist};
      OFS_TX_STATUS:  rdata = {16'h0000, st_reg.tx_word};
      OFS_INIT_BASE:  rdata = {8'h00, st_reg.init_base};
      default:        rdata = 32'h00000000;
    endcase
  end

  // Next-state logic for bus, flags, init fetch and interrupt
  always_comb
  begin
    st_next = st_reg;
    st_next.ack = req & ~st_reg.ack;
    if (req & ~st_reg.ack)
      st_next.dat = rdata;
    // Sticky flags and history from the per-bit logic
    st_next.cause = cause_next; // [R03]
    st_next.hist  = hist_next;
    if (tx_wr)
      st_next.tx_word = tx_word;
    // Init word fetch
    case (st_reg.init_st)
      INIT_IDLE:
      begin
        st_next.word_cnt = 8'h00;
        st_next.dma_addr = st_reg.init_base;
      end
      INIT_FETCH:
      begin
        if (init_dma_ack_i)
        begin
          if (init_done)
            st_next.init_st = INIT_IDLE; // [R15]
          else
          begin
            st_next.word_cnt = st_reg.word_cnt + 8'h01; // [R15]
            st_next.dma_addr = st_reg.dma_addr + WORD_BYTES; // [R15]
          end
        end
      end
      default:
      begin
        st_next.init_st = INIT_IDLE;
      end
    endcase
    // Register writes at the acknowledged edge
    if (wr_acc)
    begin
      case (adr)
        OFS_CTRL_ZERO:
        begin
          if (wb_sel_i[0])
          begin
            st_next.int_en = wb_dat_i[BIT_INT_EN]; // [R05]
            if (wb_dat_i[BIT_START])
              st_next.run = 1'b1; // [R15]
            if (wb_dat_i[BIT_INIT] && st_reg.init_st == INIT_IDLE)
            begin
              st_next.init_st  = INIT_FETCH; // [R15]
              st_next.word_cnt = 8'h00;
              st_next.dma_addr = st_reg.init_base;
            end
            if (wb_dat_i[BIT_STOP])
            begin
              st_next.run     = 1'b0;
              st_next.int_en  = 1'b0;
              st_next.cause   = '0;
              st_next.init_st = INIT_IDLE;
            end
          end
        end
        OFS_CAUSE_MASK:
        begin
          st_next.mask = (st_reg.mask & ~wmask[CAUSE_W-1:0])
                         | (wb_dat_i[CAUSE_W-1:0] & wmask[CAUSE_W-1:0]);
        end
        OFS_INIT_BASE:
        begin
          st_next.init_base = (st_reg.init_base & ~wmask[23:0]) | (wb_dat_i[23:0] & wmask[23:0]);
        end
        default:
        begin
          st_next.run = st_reg.run;
        end
      endcase
    end
    // Level output; stays high while any cause pending, so no new edge
    st_next.irq = st_reg.int_en & pending; // [R06] [R07] [R16]
  end

  // Register the whole state; mask comes up all enabled
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      st_reg         <= '0;
      st_reg.mask    <= MASK_RESET;
      st_reg.init_st <= INIT_IDLE;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  // Outputs
  assign wb_ack_o        = st_reg.ack;
  assign wb_dat_o        = st_reg.dat;
  assign irq_o           = st_reg.irq; // [R01]
  assign desc_wr_o       = tx_wr;
  assign desc_wr_addr_o  = tx_addr;
  assign desc_wr_data_o  = tx_word;
  assign init_dma_req_o  = (st_reg.init_st == INIT_FETCH);
  assign init_dma_addr_o = st_reg.dma_addr;
  assign running_o       = st_reg.run;

endmodule // host_interrupt_status_logic

// file: verification/host_irq_properties.sv
module host_irq_properties (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic        wb_ack_o,
  input wire logic        irq_o,
  input wire logic        tx_done_i,
  input wire logic [3:0]  tx_retries_i,
  input wire logic        tx_err_retry_i,
  input wire logic        tx_err_carrier_i,
  input wire logic        tx_err_late_coll_i,
  input wire logic        tx_err_underflow_i,
  input wire logic        tx_err_buffer_i,
  input wire logic [23:0] tx_desc_addr_i,
  input wire logic        desc_wr_o,
  input wire logic [23:0] desc_wr_addr_o,
  input wire logic [15:0] desc_wr_data_o,
  input wire logic        init_dma_req_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic       w0;
  logic [4:0] errs;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  // Acked control write and transmit error group
  assign w0 = wb_ack_o & wb_we_i & (wb_adr_i[7:2] == 6'h00) & wb_sel_i[0];
  assign errs = {tx_err_buffer_i, tx_err_underflow_i, tx_err_late_coll_i,
                 tx_err_carrier_i, tx_err_retry_i};
  a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack late");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  a_ie_off: assert property (w0 && !wb_dat_i[6] |=> ##1 !irq_o)
    else $error("irq despite enable off");
  a_irq_hold: assert property (irq_o && !wb_ack_o && !$past(wb_ack_o) |=> irq_o)
    else $error("irq dropped without host");
  a_dma_go: assert property (w0 && wb_dat_i[0] && !wb_dat_i[2] && !init_dma_req_o
    |=> init_dma_req_o)
    else $error("init fetch missing");
  a_desc_addr: assert property (tx_done_i |=> desc_wr_o
    && desc_wr_addr_o == $past(tx_desc_addr_i) + 24'h000002)
    else $error("status word address");
  a_tx_one: assert property (tx_done_i && tx_retries_i == 4'h1 |=>
    desc_wr_data_o[12:11] == 2'b01)
    else $error("single retry flag");
  a_tx_more: assert property (tx_done_i && tx_retries_i > 4'h1 |=>
    desc_wr_data_o[12:11] == 2'b10)
    else $error("multiple retry flag");
  a_tx_errs: assert property (tx_done_i |=> desc_wr_data_o[10:6] == $past(errs)
    && desc_wr_data_o[14] == |$past(errs))
    else $error("status error flags");
  c_init: cover property (w0 && wb_dat_i[0]);
  c_irq: cover property ($rose(irq_o));
  c_more: cover property (tx_done_i && tx_retries_i > 4'h1);
endmodule // host_irq_properties

bind host_interrupt_status_logic host_irq_properties i_props (.*);

// file: verification/init_mem_model.sv
module init_mem_model (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic req_i,
  output logic      ack_o,
  output int        words_o
);
  timeunit 1ns;
  timeprecision 100ps;
  int gap;
  // Answers each word fetch, alternately at once and after two idle cycles
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_o   <= 1'b0;
      words_o <= 0;
      gap     <= 0;
    end
    else if (ack_o || !req_i)
      ack_o <= 1'b0;
    else if (gap == 0)
    begin
      ack_o <= 1'b1;
      words_o <= words_o + 1;
      gap <= (words_o % 2) * 2;
    end
    else
      gap <= gap - 1;
  end
endmodule // init_mem_model

// file: verification/host_interrupt_status_logic_bench.sv
module host_interrupt_status_logic_bench;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'hF, tx_retries_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q;
  logic rx_done_i = 1'b0, mem_err_i = 1'b0, missed_i = 1'b0, coll_err_i = 1'b0;
  logic babble_i = 1'b0, tx_done_i = 1'b0, tx_err_retry_i = 1'b0, tx_err_carrier_i = 1'b0;
  logic tx_err_late_coll_i = 1'b0, tx_err_underflow_i = 1'b0, tx_err_buffer_i = 1'b0;
  logic [23:0] tx_desc_addr_i = 24'h000400, desc_wr_addr_o, init_dma_addr_o;
  logic [15:0] desc_wr_data_o;
  logic wb_ack_o, irq_o, desc_wr_o, init_dma_req_o, init_dma_ack_i, running_o;
  int miscompares = 0, checks_done = 0, ticks = 0, words, fetched;
  host_interrupt_status_logic i_dut (.*);
  init_mem_model i_mem (.clk_i, .rst_i, .req_i(init_dma_req_o), .ack_o(init_dma_ack_i),
    .words_o(words));
  initial forever #5 clk_i = ~clk_i;
  task close_out;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e)
    begin
      $display("BAD %s exp %h got %h", n, e, g);
      miscompares++;
    end
  endtask
  // One classic cycle, read data taken at the ack edge
  task bus(input logic [7:0] a, input logic [31:0] d, input logic w);
    @(posedge clk_i);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, w, a, d};
    do
      @(posedge clk_i);
    while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'b000;
  endtask
  // Read and compare the whole word
  task rd(input logic [7:0] a, input logic [31:0] e);
    bus(a, 32'h0, 1'b0);
    chk($sformatf("reg %h", a), e, q);
  endtask
  // One-cycle event pulse, then time for the flags to land
  task pulse(input logic [4:0] e, input logic t, input logic [3:0] r, input logic [4:0] x);
    @(posedge clk_i);
    {babble_i, coll_err_i, missed_i, mem_err_i, rx_done_i} <= e;
    {tx_err_buffer_i, tx_err_underflow_i, tx_err_late_coll_i} <= x[4:2];
    {tx_err_carrier_i, tx_err_retry_i, tx_done_i, tx_retries_i} <= {x[1:0], t, r};
    @(posedge clk_i);
    {babble_i, coll_err_i, missed_i, mem_err_i, rx_done_i, tx_done_i} <= 6'h00;
    repeat (2) @(posedge clk_i);
  endtask
  // Hand a descriptor back after its status compare; two-entry ring wraps
  task release_desc;
    if (tx_desc_addr_i == 24'h000410)
      tx_desc_addr_i <= 24'h000400;
    else
      tx_desc_addr_i <= tx_desc_addr_i + 24'h000010;
  endtask
  task irq_is(input logic e);
    repeat (2) @(posedge clk_i);
    chk("irq", {31'h0, e}, {31'h0, irq_o});
  endtask
  // Each fetched word comes from the base plus two bytes per word
  always @(posedge clk_i)
  begin
    if (init_dma_req_o !== 1'b1)
      fetched <= 0;
    else if (init_dma_ack_i === 1'b1)
    begin
      chk("fetch addr", 32'h100 + 2 * fetched, {8'h00, init_dma_addr_o});
      fetched <= fetched + 1;
    end
  end
  // Hang guard
  always @(posedge clk_i)
  begin
    ticks++;
    if (ticks == 3000)
    begin
      miscompares++;
      close_out();
    end
  end
  // Main sequence
  initial
  begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(8'h04, 32'h7F);
    rd(8'h00, 32'h4);
    bus(8'h10, 32'h100, 1'b1);
    bus(8'h00, 32'h43, 1'b1);
    while (irq_o !== 1'b1)
      @(posedge clk_i);
    chk("words", 32'd12, words);
    chk("run", 32'h1, {31'h0, running_o});
    rd(8'h00, 32'h1C2);
    bus(8'h00, 32'h140, 1'b1);
    rd(8'h00, 32'h42);
    irq_is(1'b0);
    pulse(5'h1E, 1'b0, 4'h0, 5'h00);
    rd(8'h00, 32'hF8C2);
    irq_is(1'b1);
    bus(8'h00, 32'h840, 1'b1);
    rd(8'h00, 32'hF0C2);
    bus(8'h00, 32'h8040, 1'b1);
    rd(8'h00, 32'hF0C2);
    bus(8'h00, 32'h7040, 1'b1);
    rd(8'h00, 32'h42);
    pulse(5'h01, 1'b0, 4'h0, 5'h00);
    pulse(5'h00, 1'b1, 4'h1, 5'h02);
    rd(8'h00, 32'h6C2);
    rd(8'h0C, 32'h4880);
    release_desc();
    pulse(5'h00, 1'b1, 4'h3, 5'h1D);
    rd(8'h0C, 32'h5740);
    release_desc();
    bus(8'h00, 32'h0, 1'b1);
    irq_is(1'b0);
    rd(8'h00, 32'h682);
    bus(8'h00, 32'h600, 1'b1);
    rd(8'h08, 32'h7F);
    rd(8'h08, 32'h0);
    bus(8'h04, 32'h7B, 1'b1);
    bus(8'h00, 32'h40, 1'b1);
    pulse(5'h01, 1'b0, 4'h0, 5'h00);
    irq_is(1'b0);
    rd(8'h08, 32'h4);
    bus(8'h04, 32'h7F, 1'b1);
    irq_is(1'b1);
    bus(8'h00, 32'h440, 1'b1);
    irq_is(1'b0);
    bus(8'h00, 32'h1, 1'b1);
    repeat (2) @(posedge clk_i);
    while (init_dma_req_o === 1'b1)
      @(posedge clk_i);
    irq_is(1'b0);
    rd(8'h00, 32'h182);
    bus(8'h00, 32'h4, 1'b1);
    rd(8'h00, 32'h4);
    chk("run", 32'h0, {31'h0, running_o});
    rd(8'h1C, 32'h0);
    close_out();
  end
endmodule // host_interrupt_status_logic_bench
